// [hw/ecib_bridge.sv]
// controller-to-internal-bus bridge with axi4-lite register slave
// assumes one clock; internal bus grant comes from an arbiter outside
// Overview of operation
// (RULE_01) host access to locked clock module sets violation bit 1; write 1 clears
// (RULE_02) host access to locked config space sets violation bit 0; write 1 clears
// (RULE_03) firmware keeps at most one module access enable bit set
// (RULE_04) select bit 2 enables wake-up module access; resets to 0
// (RULE_05) select bit 1 enables clock module access; resets to 0
// (RULE_06) select bit 0 enables config space access; resets to 0
// (RULE_07) clock accesses decode offset a1: pair 70h/71h or 72h/73h
// (RULE_08) writing 1 to control bit 3 pulses clock reset; bit self-clears
// (RULE_09) write-busy bit 2 set on data write, cleared when bus write completes
// (RULE_10) writing 1 to read-busy bit 1 starts bus read; 0 ignored
// (RULE_11) read-busy clears on completion; data register then holds read data
// (RULE_12) control bit 0 enables internal bus access; resets to 0
// (RULE_13) while locked, host writes ignored and host reads undefined
// (RULE_14) bus arbitration first come first served between host and controller
// (RULE_15) data register write starts bus write at indirect address offset
// (RULE_16) firmware checks both busy bits clear before starting a transfer
// (RULE_17) reserved bits read 0 and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "ecib_params.svh"

module ecib_bridge (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // axi4-lite slave
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // internal bus master towards the arbiter
    output logic             ibReq,
    input  wire logic        ibGrant,
    output logic             ibWrite,
    output logic [2:0]       ibSelect,
    output logic [7:0]       ibAddr,
    output logic [7:0]       ibWdata,
    input  wire logic [7:0]  ibRdata,
    input  wire logic        ibDone,
    // host side access reporting from the host decoders
    input  wire logic        hostConfigAccess,
    input  wire logic        hostClockAccess,
    output logic             configHostLock,
    output logic             clockHostLock,
    output logic             clockMasterReset,
    output logic             irq
);
    import ecib_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstSync1;
    logic rstSync2;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    wire logic rstLocal_n = rstSync2;

    function automatic logic [7:0] regIndex(input logic [5:0] addr);
        regIndex = {4'h0, addr[5:2]};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  indirectAddress;
    logic [7:0]  indirectData;
    logic [1:0]  hostLock;
    logic [1:0]  lockViolation;
    logic [2:0]  moduleSelect;
    logic        accessEnable;
    logic        readBusy;
    logic        writeBusy;
    logic        masterReset;
    logic [2:0]  irqStatus;
    logic [2:0]  irqMask;
    logic [7:0]  resetCnt;
    ecib_state_t state;

    // write channel: both address and data must be present
    logic [5:0]  awAddr;
    logic        awHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        wHave;
    assign s_axi_awready = !awHave && !s_axi_bvalid;
    assign s_axi_wready  = !wHave && !s_axi_bvalid;
    wire logic doWrite = awHave && wHave && !s_axi_bvalid;
    wire logic [7:0] wIdx = regIndex(awAddr);
    wire logic wLane0 = doWrite && wStrb[0];

    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            awAddr <= 6'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave <= 1'b0;
                wHave <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            indirectAddress <= `ECIB_RST_BYTE;
            hostLock <= 2'b00;
            moduleSelect <= 3'b000;
            accessEnable <= 1'b0;
            irqMask <= 3'b000;
        end else if (clkEn && wLane0) begin
            case (wIdx)
                `ECIB_IDX_INDIRECT_ADDRESS: indirectAddress <= wData[7:0];
                `ECIB_IDX_HOST_LOCK: hostLock <= wData[1:0]; // RULE_17
                `ECIB_IDX_MODULE_SELECT: moduleSelect <= wData[2:0]; // RULE_04 RULE_05 RULE_06
                `ECIB_IDX_BRIDGE_CONTROL: accessEnable <= wData[`ECIB_BIT_ACCESS_EN]; // RULE_12
                `ECIB_IDX_IRQ_MASK: irqMask <= wData[2:0];
                default: ;
            endcase
        end
    end
    assign configHostLock = hostLock[0]; // RULE_13
    assign clockHostLock = hostLock[1]; // RULE_13

    // lock violation flags; a set in the clearing cycle wins
    wire logic [1:0] violEvent = {hostClockAccess && hostLock[1],
                                  hostConfigAccess && hostLock[0]};
    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            lockViolation <= 2'b00;
        end else if (clkEn) begin
            if (wLane0 && wIdx == `ECIB_IDX_LOCK_VIOLATION) begin
                lockViolation <= (lockViolation & ~wData[1:0]) | violEvent; // RULE_01 RULE_02
            end else begin
                lockViolation <= lockViolation | violEvent; // RULE_01 RULE_02
            end
        end
    end

    // clock module reset pulse
    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            masterReset <= 1'b0;
            resetCnt <= 8'h00;
        end else if (clkEn) begin
            if (masterReset) begin
                if (resetCnt == 8'(`ECIB_MRESET_CYC - 1)) begin
                    masterReset <= 1'b0; // RULE_08
                end
                resetCnt <= resetCnt + 8'h01;
            end else if (wLane0 && wIdx == `ECIB_IDX_BRIDGE_CONTROL
                         && wData[`ECIB_BIT_MASTER_RESET]) begin
                masterReset <= 1'b1; // RULE_08
                resetCnt <= 8'h00;
            end
        end
    end
    assign clockMasterReset = masterReset;

    // ------------------------------------------------------------
    // internal bus transactions
    // ------------------------------------------------------------
    // a start while busy is dropped; firmware polls the busy bits first
    wire logic startWrite = wLane0 && wIdx == `ECIB_IDX_INDIRECT_DATA
                            && state == ECIB_IDLE; // RULE_15 RULE_16
    wire logic startRead = wLane0 && wIdx == `ECIB_IDX_BRIDGE_CONTROL
                           && wData[`ECIB_BIT_READ_BUSY] && state == ECIB_IDLE; // RULE_10
    wire logic [7:0] clockOffset = indirectAddress[1] ? `ECIB_CLOCK_PAIR_HI
                                                      : `ECIB_CLOCK_PAIR_LO;

    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            state <= ECIB_IDLE;
            readBusy <= 1'b0;
            writeBusy <= 1'b0;
            indirectData <= `ECIB_RST_BYTE;
            ibReq <= 1'b0;
            ibWrite <= 1'b0;
            ibSelect <= 3'b000;
            ibAddr <= 8'h00;
            ibWdata <= 8'h00;
        end else if (clkEn) begin
            case (state)
                ECIB_IDLE: begin
                    if (startWrite) begin
                        indirectData <= wData[7:0];
                        writeBusy <= 1'b1; // RULE_09
                    end
                    if ((startWrite || startRead) && accessEnable) begin // RULE_12
                        state <= ECIB_REQ;
                        ibReq <= 1'b1; // RULE_14
                        ibWrite <= startWrite;
                        ibSelect <= moduleSelect; // RULE_03
                        ibAddr <= moduleSelect[`ECIB_BIT_CLOCK_AE]
                                  ? (clockOffset | {7'h00, indirectAddress[0]})
                                  : indirectAddress; // RULE_07
                        ibWdata <= wData[7:0];
                        readBusy <= startRead; // RULE_10
                    end else if (startWrite) begin
                        writeBusy <= 1'b0;
                    end
                end
                ECIB_REQ: begin
                    // wait for the arbiter; a host cycle in flight holds us off
                    if (ibGrant) begin
                        state <= ECIB_WAIT; // RULE_14
                    end
                end
                ECIB_WAIT: begin
                    if (ibDone) begin
                        state <= ECIB_IDLE;
                        ibReq <= 1'b0;
                        if (ibWrite) begin
                            writeBusy <= 1'b0; // RULE_09
                        end else begin
                            indirectData <= ibRdata; // RULE_11
                            readBusy <= 1'b0; // RULE_11
                        end
                    end
                end
                default: state <= ECIB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire logic rdDone = clkEn && state == ECIB_WAIT && ibDone && !ibWrite;
    wire logic wrDone = clkEn && state == ECIB_WAIT && ibDone && ibWrite;
    wire logic [2:0] irqEvent = {|violEvent, wrDone, rdDone};
    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            irqStatus <= 3'b000;
        end else if (clkEn) begin
            if (wLane0 && wIdx == `ECIB_IDX_IRQ_STATUS) begin
                irqStatus <= (irqStatus & ~wData[2:0]) | irqEvent;
            end else begin
                irqStatus <= irqStatus | irqEvent;
            end
        end
    end
    assign irq = |(irqStatus & irqMask);

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [7:0] readValue;
    always_comb begin
        readValue = 8'h00;
        case (regIndex(s_axi_araddr))
            `ECIB_IDX_INDIRECT_ADDRESS: readValue = indirectAddress;
            `ECIB_IDX_INDIRECT_DATA: readValue = indirectData;
            `ECIB_IDX_HOST_LOCK: readValue = {6'h00, hostLock};
            `ECIB_IDX_LOCK_VIOLATION: readValue = {6'h00, lockViolation}; // RULE_17
            `ECIB_IDX_MODULE_SELECT: readValue = {5'h00, moduleSelect};
            `ECIB_IDX_BRIDGE_CONTROL:
                readValue = {4'h0, masterReset, writeBusy, readBusy, accessEnable};
            `ECIB_IDX_IRQ_STATUS: readValue = {5'h00, irqStatus};
            `ECIB_IDX_IRQ_MASK: readValue = {5'h00, irqMask};
            default: readValue = 8'h00;
        endcase
    end
    wire logic mapped = s_axi_araddr[5:2] <= 4'h7;

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, readValue};
                s_axi_rresp <= mapped ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// [hw/ecib_params.svh]
// constants for the controller-to-internal-bus bridge
// assumes inclusion by its bare name from the bridge module
`ifndef ECIB_PARAMS_SVH
`define ECIB_PARAMS_SVH

// register indices; byte address is four times the index
`define ECIB_IDX_INDIRECT_ADDRESS 8'h00
`define ECIB_IDX_INDIRECT_DATA    8'h01
`define ECIB_IDX_HOST_LOCK        8'h02
`define ECIB_IDX_LOCK_VIOLATION   8'h03
`define ECIB_IDX_MODULE_SELECT    8'h04
`define ECIB_IDX_BRIDGE_CONTROL   8'h05
`define ECIB_IDX_IRQ_STATUS       8'h06
`define ECIB_IDX_IRQ_MASK         8'h07

// field positions
`define ECIB_BIT_CONFIG_LV        0
`define ECIB_BIT_CLOCK_LV         1
`define ECIB_BIT_CONFIG_AE        0
`define ECIB_BIT_CLOCK_AE         1
`define ECIB_BIT_WAKEUP_AE        2
`define ECIB_BIT_ACCESS_EN        0
`define ECIB_BIT_READ_BUSY        1
`define ECIB_BIT_WRITE_BUSY       2
`define ECIB_BIT_MASTER_RESET     3
`define ECIB_BIT_IRQ_RDONE        0
`define ECIB_BIT_IRQ_WDONE        1
`define ECIB_BIT_IRQ_VIOL         2

// reset values
`define ECIB_RST_BYTE             8'h00

// clock module pair selection: a1 picks 70h/71h or 72h/73h
`define ECIB_CLOCK_PAIR_LO        8'h70
`define ECIB_CLOCK_PAIR_HI        8'h72

// reset pulse to the clock module
`define ECIB_MRESET_NS            100
`define ECIB_CLK_NS               25
`define ECIB_MRESET_CYC           ((`ECIB_MRESET_NS + `ECIB_CLK_NS - 1) / `ECIB_CLK_NS)

`endif

// [hw/ecib_pkg.sv]
// types for the controller-to-internal-bus bridge
// assumes nothing beyond the params header
package ecib_pkg;
    typedef enum logic [1:0] {
        ECIB_IDLE,
        ECIB_REQ,
        ECIB_WAIT
    } ecib_state_t;

    typedef enum logic [1:0] {
        ECIB_MOD_CONFIG,
        ECIB_MOD_CLOCK,
        ECIB_MOD_WAKEUP,
        ECIB_MOD_NONE
    } ecib_module_t;
endpackage

// [sim/ecib_bridge_properties.sv]
// port checker for the controller-to-internal-bus bridge
// assumes a bind from the bench top onto ecib_bridge
`timescale 1ns/1ps
`default_nettype none
module ecib_bridge_properties (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       ibReq,
    input wire logic       ibGrant,
    input wire logic       ibDone,
    input wire logic       ibWrite,
    input wire logic [2:0] ibSelect,
    input wire logic [7:0] ibAddr,
    input wire logic [7:0] ibWdata,
    input wire logic       clockMasterReset
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_mreset_len; $rose(clockMasterReset) |-> clockMasterReset [*4] ##1 !clockMasterReset;
    endproperty
    a_mreset_len: assert property (p_mreset_len) else $error("reset pulse length");
    property p_req_hold; ibReq && !ibDone |=> ibReq && $stable(ibAddr) && $stable(ibWrite);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request not held");
    property p_wdata_hold; ibReq && ibWrite && !ibDone |=> $stable(ibWdata) && $stable(ibSelect);
    endproperty
    a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved");
    property p_req_end; ibReq && ibGrant && ibDone |=> !ibReq;
    endproperty
    a_req_end: assert property (p_req_end) else $error("request after done");
    property p_grant_wait; ibReq && !ibGrant |=> ibReq;
    endproperty
    a_grant_wait: assert property (p_grant_wait) else $error("gave up waiting");
    property p_clock_pair; ibReq && ibSelect == 3'b010 |-> ibAddr[7:2] == 6'h1c;
    endproperty
    a_clock_pair: assert property (p_clock_pair) else $error("clock pair address");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read not answered");
endmodule
`default_nettype wire

// [sim/ecib_ib_partner.sv]
// arbiter plus host-domain module model on the internal bus
// assumes the bridge holds its request until done
`timescale 1ns/1ps
`default_nettype none
module ecib_ib_partner (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        slow,
    input wire logic        ibReq,
    input wire logic        ibWrite,
    input wire logic [2:0]  ibSelect,
    input wire logic [7:0]  ibAddr,
    input wire logic [7:0]  ibWdata,
    output logic            ibGrant,
    output logic [7:0]      ibRdata,
    output logic            ibDone,
    output logic [7:0]      lastAddr,
    output logic [7:0]      lastData,
    output logic [3:0]      lastKind,
    output logic [7:0]      nReq
);
    logic [3:0] waitCnt;
    logic [7:0] noise;
    // released data lines churn so a stale value cannot pass
    assign ibRdata = ibDone ? ~ibAddr : noise;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {ibGrant, ibDone, waitCnt, noise, nReq} <= '0;
            {lastAddr, lastData, lastKind} <= '0;
        end else begin
            noise <= noise + 8'h3b;
            ibDone <= 1'b0;
            if (ibReq && !ibGrant) begin
                // slow stands for a host cycle already in flight
                waitCnt <= waitCnt + 4'd1;
                if (waitCnt >= (slow ? 4'd6 : 4'd0)) begin
                    ibGrant <= 1'b1;
                    waitCnt <= 4'd0;
                end
            end else if (ibGrant && !ibDone) begin
                ibDone <= 1'b1;
                lastAddr <= ibAddr;
                lastData <= ibWdata;
                lastKind <= {ibWrite, ibSelect};
                nReq <= nReq + 8'd1;
            end else if (ibDone) begin
                ibGrant <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/ecib_bridge_tb_top.sv]
// self-checking bench for the bridge
// assumes the partner model on the internal bus
`timescale 1ns/1ps
`default_nettype none
module ecib_bridge_tb_top;
    logic        ref_clk, rst_n, clkEn, slow, irq, clockMasterReset;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, lastKind;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        ibReq, ibGrant, ibWrite, ibDone, i0, i1;
    logic [2:0]  ibSelect;
    logic [7:0]  ibAddr, ibWdata, ibRdata, lastAddr, lastData, nReq, n0;
    logic        hostConfigAccess, hostClockAccess, configHostLock, clockHostLock;
    int          n_fail = 0, checks = 0, cycles = 0, mrHigh = 0;
    ecib_bridge u_dut (
        .ref_clk, .rst_n, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ibReq, .ibGrant,
        .ibWrite, .ibSelect, .ibAddr, .ibWdata, .ibRdata, .ibDone, .hostConfigAccess,
        .hostClockAccess, .configHostLock, .clockHostLock, .clockMasterReset, .irq);
    ecib_ib_partner u_far (
        .ref_clk, .rst_n, .slow, .ibReq, .ibWrite, .ibSelect, .ibAddr, .ibWdata,
        .ibGrant, .ibRdata, .ibDone, .lastAddr, .lastData, .lastKind, .nReq);
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is combinational, so it is looked at mid-cycle before the edge
    task automatic axi_wr(input logic [3:0] idx, input logic [7:0] v);
        logic awt, wt, bt;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge ref_clk);
            awt = s_axi_awvalid && s_axi_awready;
            wt = s_axi_wvalid && s_axi_wready;
            @(posedge ref_clk);
            if (awt) s_axi_awvalid <= 1'b0;
            if (wt) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !awt) || (s_axi_wvalid && !wt));
        do begin
            @(negedge ref_clk);
            bt = s_axi_bvalid;
            @(posedge ref_clk);
        end while (!bt);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic axi_rd(input logic [3:0] idx);
        logic t;
        s_axi_araddr <= {idx, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(negedge ref_clk);
            t = s_axi_arready;
            @(posedge ref_clk);
        end while (!t);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge ref_clk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
        end while (!t);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
        axi_rd(idx);
        check(d, {24'h0, exp});
    endtask
    task automatic poll_idle();
        for (int k = 0; k < 40 && (k == 0 || d[2:1] != 2'b00); k++) axi_rd(4'h5);
        check(d[2:1], 2'b00);
    endtask
    task automatic pulse_host(input logic clk_side);
        {hostClockAccess, hostConfigAccess} <= {clk_side, !clk_side};
        @(posedge ref_clk);
        {hostClockAccess, hostConfigAccess} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic take_irq(output logic v);
        @(negedge ref_clk);
        v = irq;
        @(posedge ref_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_regs();
        rd_chk(4'h3, 8'h00);
        rd_chk(4'h4, 8'h00);
        rd_chk(4'h5, 8'h00);
        axi_wr(4'h4, 8'hf8);
        rd_chk(4'h4, 8'h00);
        axi_wr(4'h3, 8'hfc);
        rd_chk(4'h3, 8'h00);
        axi_wr(4'h5, 8'hf0);
        rd_chk(4'h5, 8'h00);
        axi_rd(4'h8);
        check(d, 32'h0000_0000);
        check({30'h0, r}, 32'h0000_0002);
    endtask
    task automatic s_write();
        logic [7:0] a;
        axi_wr(4'h5, 8'h01);
        axi_wr(4'h4, 8'h02);
        slow <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            a = k ? 8'h03 : 8'h00;
            axi_wr(4'h0, a);
            axi_wr(4'h1, 8'ha5 ^ a);
            rd_chk(4'h5, 8'h05);
            poll_idle();
            check({lastKind, lastAddr, lastData}, {4'ha, 6'h1c, a[1:0], 8'ha5 ^ a});
        end
    endtask
    task automatic s_read();
        slow <= 1'b0;
        axi_wr(4'h0, 8'h21);
        for (int k = 0; k < 3; k++) begin
            axi_wr(4'h4, 8'h01 << k);
            n0 = nReq;
            axi_wr(4'h5, 8'h01);
            repeat (8) @(posedge ref_clk);
            check(nReq, n0);
            axi_wr(4'h5, 8'h03);
            poll_idle();
            rd_chk(4'h1, (k == 1) ? 8'h8e : 8'hde);
            check(lastKind, {1'b0, 3'b001 << k});
        end
    endtask
    task automatic s_off();
        int m0;
        axi_wr(4'h5, 8'h00);
        n0 = nReq;
        axi_wr(4'h1, 8'h3c);
        repeat (8) @(posedge ref_clk);
        check(nReq, n0);
        rd_chk(4'h5, 8'h00);
        m0 = mrHigh;
        axi_wr(4'h5, 8'h08);
        repeat (10) @(posedge ref_clk);
        check(mrHigh - m0, 4);
        rd_chk(4'h5, 8'h00);
    endtask
    task automatic s_viol();
        pulse_host(1'b0);
        rd_chk(4'h3, 8'h00);
        axi_wr(4'h2, 8'h03);
        check({configHostLock, clockHostLock}, 2'b11);
        pulse_host(1'b0);
        rd_chk(4'h3, 8'h01);
        pulse_host(1'b1);
        rd_chk(4'h3, 8'h03);
        rd_chk(4'h6, 8'h07);
        axi_wr(4'h7, 8'h00);
        take_irq(i0);
        axi_wr(4'h7, 8'hff);
        take_irq(i1);
        check(i0 ^ i1, 1'b1);
        axi_wr(4'h3, 8'h01);
        rd_chk(4'h3, 8'h02);
        axi_wr(4'h3, 8'h02);
        rd_chk(4'h3, 8'h00);
        clkEn <= 1'b0;
        pulse_host(1'b1);
        clkEn <= 1'b1;
        rd_chk(4'h3, 8'h00);
        axi_wr(4'h6, 8'hff);
        take_irq(i0);
        check(i0, 1'b0);
    endtask
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) if (clockMasterReset === 1'b1) mrHigh++;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        {rst_n, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, hostConfigAccess, hostClockAccess} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        clkEn = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        s_regs();
        s_write();
        s_read();
        s_off();
        s_viol();
        close_out();
    end
endmodule
bind ecib_bridge ecib_bridge_properties u_props (
    .ref_clk, .rst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .ibReq, .ibGrant, .ibDone, .ibWrite, .ibSelect,
    .ibAddr, .ibWdata, .clockMasterReset);
`default_nettype wire
